// ---- design/ccsc_cache_unit_config.v ----
`timescale 1ns/1ps
`include "ccsc_consts.vh"
// Functional notes
// - write to data port stages six bits
// - staged bits enter chain at retire
// - read of data port returns shifted bits
// - trigger bit zero loads data port
// - multibit fields sit lsb first
// - boot chain field order fixed
// - first bit enables wide io mode
// - victim threshold passed raw, eight bits wide
// - clean victims sent only when enabled
// - duplicate directory and probe-only enables
// - fast move disabled by bit
// - read-with-evict mode enable bit
// - ack hold stops counter increment
// - barrier commands only when enabled
// - five-bit ack limit, three-bit evict limit
// - four turnaround gap fields
// - board cache bank enable bit
// - bus width two bits, format bit
// - boot loads 367 bits lsb first
// - 36-bit runtime chain, six per write
// - trigger removes six error bits
module ccsc_cache_unit_config #(
    parameter GW   = `CCSC_GROUP_W,
    parameter RLEN = `CCSC_RUN_LEN,
    parameter ELEN = `CCSC_ERR_LEN
) (
    input  wire             clock,
    input  wire             resetn,
    // privileged register port
    input  wire             port_write,
    input  wire [63:0]      port_wdata,
    input  wire             port_write_retire,
    input  wire             trigger_write,
    input  wire [63:0]      trigger_wdata,
    input  wire             port_read,
    output wire [63:0]      port_rdata,
    // error capture chain load
    input  wire             err_load,
    input  wire [ELEN-1:0]  err_value,
    // boot serial rom
    input  wire             boot_start,
    input  wire             boot_rom_bit,
    output wire             boot_rom_req,
    output wire             boot_done,
    // decoded configuration
    output wire [RLEN-1:0]  runtime_chain,
    output wire             wide_io_enable,
    output wire             offset_fill_flag,
    output wire [7:0]       victim_stream_threshold,
    output wire             clean_evict_enable,
    output wire [1:0]       system_bus_width,
    output wire             system_bus_layout,
    output wire [3:0]       system_clock_multiplier,
    output wire             clock_multiplier_valid,
    output wire             duplicate_directory_enable,
    output wire             probe_directory_only,
    output wire             fast_move_enable,
    output wire             read_with_evict_mode,
    output wire             evict_read_ack_hold,
    output wire             barrier_command_enable,
    output wire [4:0]       ack_limit,
    output wire [2:0]       evict_count_limit,
    output wire             write_write_gap,
    output wire [5:0]       read_write_gap,
    output wire             read_read_gap,
    output wire             board_cache_bank_enable,
    output wire [3:0]       write_read_gap,
    // use gates for the rest of the cache unit
    input  wire             clean_victim_req,
    output wire             clean_victim_send,
    input  wire             barrier_req,
    output wire             barrier_send,
    input  wire             read_evict_cmd,
    output wire             ack_count_inc,
    output wire             duplicate_mismatch
);
    // ---------------------------------------------
    // data port, staging and chains
    // ---------------------------------------------
    reg [GW-1:0]    data_port;
    reg [GW-1:0]    staging;
    reg             staged;
    reg [RLEN-1:0]  run_chain;
    reg [ELEN-1:0]  err_chain;
    wire [`CCSC_BOOT_LEN-1:0] boot;

    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            data_port <= 6'h00;
            staging   <= 6'h00;
            staged    <= 1'b0;
            run_chain <= {RLEN{1'b0}};
            err_chain <= {ELEN{1'b0}};
        end else begin
            if (port_write) begin
                data_port <= port_wdata[GW-1:0];
                staging   <= port_wdata[GW-1:0];
                staged    <= 1'b1;
            end else if (trigger_write && trigger_wdata[0]) begin
                data_port <= err_chain[GW-1:0];
            end
            // retire of a write in the same cycle as a new one uses the new bits
            if (port_write_retire && (staged || port_write)) begin
                run_chain <= {(port_write ? port_wdata[GW-1:0] : staging),
                              run_chain[RLEN-1:GW]};
                staged    <= 1'b0;
            end
            if (err_load) begin
                err_chain <= err_value;
            end else if (trigger_write && trigger_wdata[0]) begin
                err_chain <= {{GW{1'b0}}, err_chain[ELEN-1:GW]};
            end
        end
    end

    assign port_rdata = port_read ? {58'h0, data_port} : 64'h0;
    assign runtime_chain = run_chain;

    // ---------------------------------------------
    // boot chain and field decode
    // ---------------------------------------------
    ccsc_boot_loader #(.LEN(`CCSC_BOOT_LEN)) i_ccsc_boot_loader (
        .clock   (clock),
        .resetn  (resetn),
        .start   (boot_start),
        .rom_bit (boot_rom_bit),
        .rom_req (boot_rom_req),
        .chain   (boot),
        .done    (boot_done)
    );

    // chain starts at lsb; a field's lsb is its lowest chain index
    assign wide_io_enable             = boot[`CCSC_F_WIDE_IO];
    assign offset_fill_flag           = boot[`CCSC_F_FILL0];
    assign victim_stream_threshold    = boot[`CCSC_F_VIC_THR +: 8];
    assign clean_evict_enable         = boot[`CCSC_F_CLEAN0];
    assign system_bus_width           = boot[`CCSC_F_BUS_W +: 2];
    assign system_bus_layout          = boot[`CCSC_F_BUS_FMT];
    assign system_clock_multiplier    = boot[`CCSC_F_CLK_MUL +: 4];
    assign duplicate_directory_enable = boot[`CCSC_F_DUP_DIR];
    assign probe_directory_only       = boot[`CCSC_F_PRB_ONLY];
    assign fast_move_enable           = ~boot[`CCSC_F_FAST_DIS];
    assign read_with_evict_mode       = boot[`CCSC_F_RD_EVICT];
    assign evict_read_ack_hold        = boot[`CCSC_F_ACK_HOLD];
    assign barrier_command_enable     = boot[`CCSC_F_BARRIER];
    assign ack_limit                  = boot[`CCSC_F_ACK_LIM +: 5];
    assign evict_count_limit          = boot[`CCSC_F_EVICT_LIM +: 3];
    assign write_write_gap            = boot[`CCSC_F_WW_GAP];
    assign read_write_gap             = boot[`CCSC_F_RW_GAP +: 6];
    assign read_read_gap              = boot[`CCSC_F_RR_GAP];
    assign board_cache_bank_enable    = boot[`CCSC_F_BANK_EN];
    assign write_read_gap             = boot[`CCSC_F_WR_GAP +: 4];

    // only the four one-hot codes are legal multipliers
    function onehot4;
        input [3:0] v;
        begin
            onehot4 = (v == 4'h1) || (v == 4'h2) || (v == 4'h4) || (v == 4'h8);
        end
    endfunction
    assign clock_multiplier_valid = onehot4(system_clock_multiplier);

    // ---------------------------------------------
    // gates driven by the configuration
    // ---------------------------------------------
    assign clean_victim_send = clean_victim_req & clean_evict_enable;
    assign barrier_send      = barrier_req & barrier_command_enable;
    assign ack_count_inc     = read_evict_cmd & ~evict_read_ack_hold;
    // flags a software slip; duplicates must match originals
    assign duplicate_mismatch = boot_done &
        ((boot[`CCSC_F_FILL1] != boot[`CCSC_F_FILL0]) |
         (boot[`CCSC_F_CLEAN1] != boot[`CCSC_F_CLEAN0]) |
         (boot[`CCSC_F_CLEAN2] != boot[`CCSC_F_CLEAN0]));
endmodule // ccsc_cache_unit_config

// ---- shared/ccsc_consts.vh ----
`ifndef CCSC_CONSTS_VH
`define CCSC_CONSTS_VH
// ---------------------------------------------
// chain sizes
// ---------------------------------------------
`define CCSC_GROUP_W        6
`define CCSC_BOOT_LEN       367
`define CCSC_RUN_LEN        36
`define CCSC_ERR_LEN        60
`define CCSC_BOOT_CNT_W     9
// ---------------------------------------------
// boot chain field positions (lsb index, chain order)
// ---------------------------------------------
`define CCSC_F_WIDE_IO      0
`define CCSC_F_FILL0        1
`define CCSC_F_FILL1        2
`define CCSC_F_VIC_THR      3
`define CCSC_F_CLEAN0       11
`define CCSC_F_BUS_W        12
`define CCSC_F_BUS_FMT      14
`define CCSC_F_CLK_MUL      15
`define CCSC_F_DUP_DIR      19
`define CCSC_F_PRB_ONLY     20
`define CCSC_F_FAST_DIS     21
`define CCSC_F_RD_EVICT     22
`define CCSC_F_CLEAN1       23
`define CCSC_F_ACK_HOLD     24
`define CCSC_F_BARRIER      25
`define CCSC_F_ACK_LIM      26
`define CCSC_F_EVICT_LIM    31
`define CCSC_F_CLEAN2       34
`define CCSC_F_WW_GAP       35
`define CCSC_F_RW_GAP       36
`define CCSC_F_RR_GAP       42
`define CCSC_F_BANK_EN      43
`define CCSC_F_WR_GAP       44
`define CCSC_F_END          48
`endif

// ---- design/ccsc_boot_loader.v ----
`timescale 1ns/1ps
`include "ccsc_consts.vh"
module ccsc_boot_loader #(
    parameter LEN = `CCSC_BOOT_LEN
) (
    input  wire             clock,
    input  wire             resetn,
    input  wire             start,
    input  wire             rom_bit,
    output wire             rom_req,
    output reg  [LEN-1:0]   chain,
    output reg              done
);
    // ---------------------------------------------
    // serial boot load, lsb arrives first
    // ---------------------------------------------
    reg [`CCSC_BOOT_CNT_W-1:0] count;
    reg                        busy;
    assign rom_req = busy;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            chain <= {LEN{1'b0}};
            count <= 9'h000;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else if (start && !busy && !done) begin
            busy  <= 1'b1;
            count <= 9'h000;
        end else if (busy) begin
            // shift toward lsb so first bit ends at index zero; overflow bits drop off
            chain <= {rom_bit, chain[LEN-1:1]};
            if (count == LEN[8:0] - 9'h001) begin
                busy <= 1'b0;
                done <= 1'b1;
            end
            count <= count + 9'h001;
        end
    end
endmodule // ccsc_boot_loader

// ---- sim/ccsc_props.sv ----
`timescale 1ns/1ps
module ccsc_props #(
    parameter RLEN = 36
) (
    input wire            clock,
    input wire            resetn,
    input wire            port_write,
    input wire            port_write_retire,
    input wire            trigger_write,
    input wire            port_read,
    input wire [63:0]     port_wdata,
    input wire [63:0]     trigger_wdata,
    input wire [63:0]     port_rdata,
    input wire            boot_start,
    input wire            boot_rom_req,
    input wire            boot_done,
    input wire [RLEN-1:0] runtime_chain,
    input wire            clean_evict_enable,
    input wire            clean_victim_req,
    input wire            clean_victim_send,
    input wire            barrier_command_enable,
    input wire            barrier_req,
    input wire            barrier_send,
    input wire            evict_read_ack_hold,
    input wire            read_evict_cmd,
    input wire            ack_count_inc
);
// ------------------------------
// port, chain and gate checks
// ------------------------------
default clocking cb @(posedge clock); endclocking
default disable iff (!resetn);
// only a port write or a trigger write with bit zero high moves the port; others must leave it alone
wire trig = trigger_write & trigger_wdata[0];
sequence s_stage;
    port_write && !port_write_retire ##1 port_write_retire && !port_write;
endsequence
sequence s_boot_run;
    boot_rom_req [*8] ##[359:361] boot_done;
endsequence
chk_write_load: assert property (port_write ##1 port_read |-> port_rdata[5:0] == $past(port_wdata[5:0]))
    else $error("data port missed a write");
chk_retire_shift: assert property (s_stage |=>
    runtime_chain == {$past(port_wdata[5:0], 2), $past(runtime_chain[RLEN-1:6])})
    else $error("chain did not take the staged group");
chk_chain_hold: assert property (!port_write_retire |=> $stable(runtime_chain))
    else $error("chain moved without a retire");
chk_read_gate: assert property (port_rdata[63:6] == 58'h0 && (port_read || port_rdata == 64'h0))
    else $error("read data outside its field or window");
chk_port_hold: assert property (port_read && !port_write && !trig ##1 port_read |-> $stable(port_rdata))
    else $error("data port changed without an access");
chk_clean_gate: assert property (clean_victim_send == (clean_victim_req && clean_evict_enable))
    else $error("clean victim gate wrong");
chk_barrier_gate: assert property (barrier_send == (barrier_req && barrier_command_enable))
    else $error("barrier gate wrong");
chk_ack_hold: assert property (ack_count_inc == (read_evict_cmd && !evict_read_ack_hold))
    else $error("ack counter gate wrong");
chk_boot_run: assert property (boot_start && !boot_rom_req && !boot_done |=> s_boot_run)
    else $error("boot load length wrong");
endmodule // ccsc_props
bind ccsc_cache_unit_config ccsc_props #(.RLEN(RLEN)) i_ccsc_props (
    .clock, .resetn, .port_write, .port_write_retire, .trigger_write, .port_read, .port_wdata,
    .trigger_wdata, .port_rdata, .boot_start, .boot_rom_req, .boot_done, .runtime_chain,
    .clean_evict_enable, .clean_victim_req, .clean_victim_send, .barrier_command_enable,
    .barrier_req, .barrier_send, .evict_read_ack_hold, .read_evict_cmd, .ack_count_inc
);

// ---- sim/test_cache_unit_config_shift_chain.sv ----
`timescale 1ns/1ps
module test_cache_unit_config_shift_chain;
// ------------------------------
// drive and observe
// ------------------------------
reg          clock = 1'b0, resetn = 1'b0, port_write = 1'b0, port_write_retire = 1'b0, trigger_write = 1'b0;
reg          port_read = 1'b1, err_load = 1'b0, boot_start = 1'b0, boot_rom_bit = 1'b0;
reg  [63:0]  port_wdata = 64'h0, trigger_wdata = 64'h0;
reg  [59:0]  err_value = 60'h0;
reg  [2:0]   req = 3'h0;
reg  [11:0]  rows [0:5];
reg  [366:0] img;
reg  [35:0]  chain_exp;
integer      fail_count = 0, checks_done = 0, k;
wire [63:0]  port_rdata;
wire [35:0]  runtime_chain;
wire [47:0]  dec;
wire [2:0]   gate;
wire         mul_ok, dup_bad, boot_done, rom_req;
// duplicate slots mirror their original so one compare covers the field map
assign dec[2] = dec[1];
assign dec[23] = dec[11];
assign dec[34] = dec[11];
always #50 clock = ~clock;
always @(posedge clock) req <= req + 3'h1;
ccsc_cache_unit_config i_ccsc_cache_unit_config (
    .clock(clock), .resetn(resetn), .port_write(port_write), .port_wdata(port_wdata),
    .port_write_retire(port_write_retire), .trigger_write(trigger_write), .trigger_wdata(trigger_wdata),
    .port_read(port_read), .port_rdata(port_rdata), .err_load(err_load), .err_value(err_value),
    .boot_start(boot_start), .boot_rom_bit(boot_rom_bit), .boot_rom_req(rom_req), .boot_done(boot_done),
    .runtime_chain(runtime_chain), .wide_io_enable(dec[0]), .offset_fill_flag(dec[1]),
    .victim_stream_threshold(dec[10:3]), .clean_evict_enable(dec[11]), .system_bus_width(dec[13:12]),
    .system_bus_layout(dec[14]), .system_clock_multiplier(dec[18:15]), .clock_multiplier_valid(mul_ok),
    .duplicate_directory_enable(dec[19]), .probe_directory_only(dec[20]), .fast_move_enable(dec[21]),
    .read_with_evict_mode(dec[22]), .evict_read_ack_hold(dec[24]), .barrier_command_enable(dec[25]),
    .ack_limit(dec[30:26]), .evict_count_limit(dec[33:31]), .write_write_gap(dec[35]),
    .read_write_gap(dec[41:36]), .read_read_gap(dec[42]), .board_cache_bank_enable(dec[43]),
    .write_read_gap(dec[47:44]), .clean_victim_req(req[0]), .clean_victim_send(gate[0]), .barrier_req(req[1]),
    .barrier_send(gate[1]), .read_evict_cmd(req[2]), .ack_count_inc(gate[2]), .duplicate_mismatch(dup_bad)
);
task check(input [63:0] got, input [63:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
            fail_count = fail_count + 1;
        end
    end
endtask
task results;
    begin
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    end
endtask
// first bit sent lands at chain position zero; unused tail bits are zero
task boot(input [47:0] p, input [47:0] e, input ok, input bad);
    begin
        img = {319'h0, p};
        @(posedge clock);
        boot_start <= 1'b1;
        for (k = 0; k < 367; k = k + 1) begin
            @(posedge clock);
            boot_start <= 1'b0;
            boot_rom_bit <= img[k];
        end
        for (k = 0; k < 20 && boot_done !== 1'b1; k = k + 1) begin
            @(posedge clock);
            #1;
        end
        if (k == 20) begin
            fail_count = fail_count + 1;
            results;
        end
        check(dec, e);
        check(mul_ok, ok);
        check(dup_bad, bad);
        // the request counter walks all eight combinations of the three gate inputs
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge clock);
            #1 check({rom_req, gate}, {1'b0, req[2] & ~e[24], req[1] & e[25], req[0] & e[11]});
        end
    end
endtask
initial begin
    rows[0] = {6'h2A, 6'h2A};
    rows[1] = {6'h15, 6'h15};
    rows[2] = {6'h3F, 6'h3F};
    rows[3] = {6'h00, 6'h00};
    rows[4] = {6'h01, 6'h01};
    rows[5] = {6'h20, 6'h20};
    chain_exp = 36'h0;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    for (k = 0; k < 6; k = k + 1) begin
        @(posedge clock);
        port_write <= 1'b1;
        port_wdata <= {58'h2AAAAAAAAAAAAAA, rows[k][11:6]};
        @(posedge clock);
        port_write <= 1'b0;
        port_write_retire <= 1'b1;
        #1 check(port_rdata, rows[k][5:0]);
        @(posedge clock);
        port_write_retire <= 1'b0;
        chain_exp = {rows[k][5:0], chain_exp[35:6]};
        #1 check(runtime_chain, chain_exp);
    end
    @(posedge clock);
    port_write_retire <= 1'b1;
    port_read <= 1'b0;
    #1 check(port_rdata, 64'h0);
    @(posedge clock);
    port_write_retire <= 1'b0;
    port_read <= 1'b1;
    err_load <= 1'b1;
    err_value <= 60'hF123456789ABCDE;
    #1 check(runtime_chain, chain_exp);
    @(posedge clock);
    err_load <= 1'b0;
    trigger_write <= 1'b1;
    trigger_wdata <= 64'hFFFFFFFFFFFFFFFE;
    @(posedge clock);
    trigger_wdata <= 64'h1;
    #1 check(port_rdata, 64'h20);
    for (k = 0; k < 11; k = k + 1) begin
        @(posedge clock);
        trigger_write <= (k < 10);
        #1 check(port_rdata, (err_value >> (6 * k)) & 60'h3F);
    end
    boot(48'hA6D6CDAA2907, 48'hA6D6CD8A2907, 1'b1, 1'b0);
    @(posedge clock);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    #1 check(runtime_chain, 36'h0);
    check(dec, 48'h200000);
    check({boot_done, port_rdata[5:0]}, 7'h0);
    boot(48'hA6D6CEA9A903, 48'hA6D6CE89A907, 1'b0, 1'b1);
    results;
end
endmodule // test_cache_unit_config_shift_chain
